/* File: hdl/dps_pkg.sv */
// Purpose: Constants for the debug and serial pin function select
// Assumes: Field codes below match the pad configuration encoding
// Notes:   Shared by the select top and its two cells
package dps_pkg;

  // ----------------------------------------------------------------
  // Pad configuration fields
  // ----------------------------------------------------------------
  localparam logic [3:0] DPS_CFG_ALT_OUT = 4'h9;
  localparam logic [3:0] DPS_CFG_ALT_OD = 4'hd;
  localparam int DPS_PB2_FIELD_LSB = 8;
  localparam int DPS_PC2_FIELD_LSB = 8;
  localparam int DPS_PC3_FIELD_LSB = 12;
  localparam int DPS_FIELD_W = 4;
  localparam int DPS_PCH_PC2_BIT = 1;
  localparam int DPS_DBG_GPIO_BIT = 5;
  localparam int DPS_T2_REMAP_BIT = 5;

  // ----------------------------------------------------------------
  // Serial controller modes
  // ----------------------------------------------------------------
  localparam logic [1:0] DPS_SC_OFF = 2'h0;
  localparam logic [1:0] DPS_SC_UART = 2'h1;
  localparam logic [1:0] DPS_SC_SPI = 2'h2;
  localparam logic [1:0] DPS_SC_TWI = 2'h3;

  // ----------------------------------------------------------------
  // Pad indices and reset values
  // ----------------------------------------------------------------
  localparam int DPS_NPAD = 5;
  localparam int DPS_PAD_PB2 = 0;
  localparam int DPS_PAD_DCK = 1;
  localparam int DPS_PAD_PC2 = 2;
  localparam int DPS_PAD_PC3 = 3;
  localparam int DPS_PAD_PC4 = 4;
  localparam logic DPS_PAD_RST = 1'b0;
  localparam logic DPS_IDLE_HIGH = 1'b1;

  typedef enum logic [1:0] {
    DPS_MODE_JTAG = 2'b01,
    DPS_MODE_SW = 2'b10
  } dps_mode_t;

endpackage

/* File: hdl/dps_pad_cell.sv */
// Purpose: Registered output stage of one shared pad
// Assumes: Alternate function wins over general-purpose control
// Notes:   Pulls are decided by the caller
`timescale 1ns/1ps
module dps_pad_cell
  import dps_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic alt_en_in,
  input wire logic alt_out_in,
  input wire logic alt_oe_in,
  input wire logic gp_out_in,
  input wire logic gp_oe_in,
  input wire logic pull_up_in,
  input wire logic pull_down_in,
  output logic pad_out,
  output logic pad_oe_out,
  output logic pull_up_out,
  output logic pull_down_out
);

  // ----------------------------------------------------------------
  // Drive selection
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pad_out <= DPS_PAD_RST;
      pad_oe_out <= DPS_PAD_RST;
    end else if (ce_in) begin
      pad_out <= alt_en_in ? alt_out_in : gp_out_in;
      pad_oe_out <= alt_en_in ? alt_oe_in : gp_oe_in;
    end
  end

  // ----------------------------------------------------------------
  // Pulls
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pull_up_out <= DPS_PAD_RST;
      pull_down_out <= DPS_PAD_RST;
    end else if (ce_in) begin
      pull_up_out <= pull_up_in;
      pull_down_out <= pull_down_in;
    end
  end

endmodule

/* File: hdl/dps_dbg_mode.sv */
// Purpose: Debug port mode, JTAG or serial-wire
// Assumes: Switch request is a one-cycle pulse from the debug unit
// Notes:   External reset low always wins over a switch request
`timescale 1ns/1ps
module dps_dbg_mode
  import dps_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic ext_reset_n_in,
  input wire logic sw_req_in,
  output logic sw_mode_out
);

  dps_mode_t state_r;
  dps_mode_t state_nxt;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DPS_MODE_JTAG: begin
        if (sw_req_in) begin
          state_nxt = DPS_MODE_SW;
        end
      end
      DPS_MODE_SW: begin
        state_nxt = DPS_MODE_SW;
      end
      default: begin
        state_nxt = DPS_MODE_JTAG;
      end
    endcase
    // Reset pin forces JTAG
    if (!ext_reset_n_in) begin
      state_nxt = DPS_MODE_JTAG;
    end
  end

  // R16: JTAG after power-up
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= DPS_MODE_JTAG;
    end else if (ce_in) begin
      state_r <= state_nxt;
    end
  end

  assign sw_mode_out = state_r[1];

  property p_ext_reset_jtag;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && !ext_reset_n_in |=> !sw_mode_out;
  endproperty
  a_ext_reset_jtag: assert property (p_ext_reset_jtag) // R16
    else $error("Reset pin did not force JTAG mode");

  sequence s_switch;
    ce_in && sw_req_in && ext_reset_n_in;
  endsequence
  property p_switch_sw;
    @(posedge clk_in) disable iff (rst_in)
    s_switch |=> sw_mode_out;
  endproperty
  a_switch_sw: assert property (p_switch_sw) // R18
    else $error("Switch request did not enter serial-wire mode");

endmodule

/* File: hdl/dps_pin_select.sv */
// Purpose: Function select for port B pin 2 and the debug pins
// Assumes: All inputs synchronous to clk_in; one-cycle output latency
// Notes:   Pad index 0 pb2, 1 debug clock, 2..4 port C pins 2..4
`timescale 1ns/1ps

// Summary of operation
// R1: SPI master routes port_b_pin2 as data in
// R2: SPI slave routes port_b_pin2 as data in
// R3: Two-wire clock open-drain when timer not remapped
// R4: UART mode receives from port_b_pin2
// R5: Remapped enabled timer channel drives port_b_pin2
// R6: Remapped timer channel input from port_b_pin2
// R7: Debug clock: serial-wire bidir, JTAG input pulled down
// R8: port_c_pin2 GPIO needs debug bit and high-config clear
// R9: JTAG mode drives data out on port_c_pin2
// R10: Async trace out in serial-wire, pulled up
// R11: Sync trace data line on port_c_pin2
// R12: port_c_pin3 GPIO with debug bit or serial-wire
// R13: JTAG data in on port_c_pin3, pulled up
// R14: Sync trace clock on port_c_pin3
// R15: port_c_pin4 GPIO only with debug bit
// R16: JTAG mode after power-up and reset pin
// R17: JTAG mode select on port_c_pin4, pulled up
// R18: Debugger switch gives serial-wire data on port_c_pin4
// R19: No alternate function leaves pin to GPIO
module dps_pin_select
  import dps_pkg::*;
#(
  parameter int CFG_W = 16,
  parameter int DBG_W = 8,
  parameter int REMAP_W = 8
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic external_reset_pin_n_in,
  input wire logic sw_switch_req_in,
  input wire logic [1:0] serctl1_mode_select_in,
  input wire logic serctl1_spi_config_master_in,
  input wire logic serctl1_twowire_drive_low_in,
  input wire logic timer2_output_enable_reg_in,
  input wire logic [REMAP_W-1:0] timer2_remap_reg_in,
  input wire logic timer2_channel2_drive_in,
  input wire logic [CFG_W-1:0] port_b_low_config_in,
  input wire logic [CFG_W-1:0] port_c_low_config_in,
  input wire logic [CFG_W-1:0] port_c_high_config_in,
  input wire logic [DBG_W-1:0] debug_pin_config_in,
  input wire logic trace_enable_in,
  input wire logic trace_async_sel_in,
  input wire logic trace_sync4_sel_in,
  input wire logic async_trace_data_in,
  input wire logic sync_trace_data_in,
  input wire logic sync_trace_clock_in,
  input wire logic jtag_data_out_in,
  input wire logic sw_clock_drive_in,
  input wire logic sw_clock_oe_in,
  input wire logic sw_data_drive_in,
  input wire logic sw_data_oe_in,
  input wire logic [3:0] gpio_drive_in,
  input wire logic [3:0] gpio_oe_in,
  input wire logic [DPS_NPAD-1:0] pad_in,
  output logic [DPS_NPAD-1:0] pad_out,
  output logic [DPS_NPAD-1:0] pad_oe_out,
  output logic [DPS_NPAD-1:0] pad_pull_up_out,
  output logic [DPS_NPAD-1:0] pad_pull_down_out,
  output logic [3:0] gpio_sample_out,
  output logic serctl1_spi_master_in_out,
  output logic serctl1_spi_slave_in_out,
  output logic serctl1_uart_receive_out,
  output logic serctl1_twowire_clock_out,
  output logic timer2_channel2_out,
  output logic jtag_clock_pin_out,
  output logic jtag_data_in_pin_out,
  output logic jtag_mode_select_pin_out,
  output logic sw_clock_out,
  output logic sw_data_out,
  output logic debug_sw_mode_out
);

  logic sw_mode;
  logic jtag_mode;
  logic [3:0] pb2_field;
  logic [3:0] pc2_field;
  logic [3:0] pc3_field;
  logic sc_spi;
  logic sc_twi;
  logic sc_uart;
  logic t2_remap;
  logic t2_drive;
  logic scl_sel;
  logic dbg_gpio;
  logic pc2_gpio;
  logic pc2_sync;
  logic pc2_async;
  logic pc2_tdo;
  logic pc3_clk;
  logic pc3_gpio;
  logic [DPS_NPAD-1:0] alt_en;
  logic [DPS_NPAD-1:0] alt_out;
  logic [DPS_NPAD-1:0] alt_oe;
  logic [DPS_NPAD-1:0] gp_out;
  logic [DPS_NPAD-1:0] gp_oe;
  logic [DPS_NPAD-1:0] pu;
  logic [DPS_NPAD-1:0] pd;

  // ----------------------------------------------------------------
  // Debug mode
  // ----------------------------------------------------------------
  dps_dbg_mode u_mode (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .ext_reset_n_in(external_reset_pin_n_in),
    .sw_req_in(sw_switch_req_in),
    .sw_mode_out(sw_mode)
  );

  assign jtag_mode = !sw_mode;
  assign debug_sw_mode_out = sw_mode;

  // ----------------------------------------------------------------
  // Select decode
  // ----------------------------------------------------------------
  assign pb2_field = port_b_low_config_in[DPS_PB2_FIELD_LSB +: DPS_FIELD_W];
  assign pc2_field = port_c_low_config_in[DPS_PC2_FIELD_LSB +: DPS_FIELD_W];
  assign pc3_field = port_c_low_config_in[DPS_PC3_FIELD_LSB +: DPS_FIELD_W];
  assign sc_spi = serctl1_mode_select_in == DPS_SC_SPI;
  assign sc_twi = serctl1_mode_select_in == DPS_SC_TWI;
  assign sc_uart = serctl1_mode_select_in == DPS_SC_UART;
  assign t2_remap = timer2_remap_reg_in[DPS_T2_REMAP_BIT];
  assign dbg_gpio = debug_pin_config_in[DPS_DBG_GPIO_BIT];

  // R5: remapped timer output
  assign t2_drive = t2_remap && timer2_output_enable_reg_in &&
                    pb2_field == DPS_CFG_ALT_OUT;
  // R3: two-wire clock only if timer not on the pin
  assign scl_sel = sc_twi && pb2_field == DPS_CFG_ALT_OD &&
                   !(timer2_output_enable_reg_in && t2_remap);
  // R8: GPIO release of port_c_pin2
  assign pc2_gpio = dbg_gpio && !port_c_high_config_in[DPS_PCH_PC2_BIT];
  // R11: four-wire sync trace data
  assign pc2_sync = trace_enable_in && trace_sync4_sel_in &&
                    pc2_field == DPS_CFG_ALT_OUT;
  // R10: async trace needs serial-wire mode
  assign pc2_async = trace_enable_in && trace_async_sel_in &&
                     pc2_field == DPS_CFG_ALT_OUT && sw_mode;
  // R9: JTAG data out unless released
  assign pc2_tdo = jtag_mode && !pc2_gpio;
  // R14: sync trace clock
  assign pc3_clk = trace_enable_in && pc3_field == DPS_CFG_ALT_OUT;
  // R12: GPIO release of port_c_pin3
  assign pc3_gpio = dbg_gpio || sw_mode;

  // ----------------------------------------------------------------
  // Per-pad alternate and GPIO terms
  // ----------------------------------------------------------------
  always_comb begin
    alt_en = '0;
    alt_out = '0;
    alt_oe = '0;
    pu = '0;
    pd = '0;
    // R19: GPIO control by default
    gp_out = {gpio_drive_in[3:1], 1'b0, gpio_drive_in[0]};
    gp_oe = {gpio_oe_in[3:1], 1'b0, gpio_oe_in[0]};

    // Timer first, so a remap collision never fights the clock
    if (t2_drive) begin
      alt_en[DPS_PAD_PB2] = 1'b1;
      alt_out[DPS_PAD_PB2] = timer2_channel2_drive_in;
      alt_oe[DPS_PAD_PB2] = 1'b1;
    end else if (scl_sel) begin
      // Open drain: drive low only
      alt_en[DPS_PAD_PB2] = 1'b1;
      alt_oe[DPS_PAD_PB2] = serctl1_twowire_drive_low_in;
    end

    // R7: debug clock pin
    alt_en[DPS_PAD_DCK] = 1'b1;
    if (sw_mode) begin
      alt_out[DPS_PAD_DCK] = sw_clock_drive_in;
      alt_oe[DPS_PAD_DCK] = sw_clock_oe_in;
    end else begin
      pd[DPS_PAD_DCK] = 1'b1;
    end

    // Trace before debug; sync wins over async on a clash
    if (pc2_sync) begin
      alt_en[DPS_PAD_PC2] = 1'b1;
      alt_out[DPS_PAD_PC2] = sync_trace_data_in;
      alt_oe[DPS_PAD_PC2] = 1'b1;
    end else if (pc2_async) begin
      alt_en[DPS_PAD_PC2] = 1'b1;
      alt_out[DPS_PAD_PC2] = async_trace_data_in;
      alt_oe[DPS_PAD_PC2] = 1'b1;
      pu[DPS_PAD_PC2] = 1'b1;
    end else if (pc2_tdo) begin
      alt_en[DPS_PAD_PC2] = 1'b1;
      alt_out[DPS_PAD_PC2] = jtag_data_out_in;
      alt_oe[DPS_PAD_PC2] = 1'b1;
    end else if (!pc2_gpio) begin
      // Not released: keep the pad off
      alt_en[DPS_PAD_PC2] = 1'b1;
    end

    if (pc3_clk) begin
      alt_en[DPS_PAD_PC3] = 1'b1;
      alt_out[DPS_PAD_PC3] = sync_trace_clock_in;
      alt_oe[DPS_PAD_PC3] = 1'b1;
    end else if (!pc3_gpio) begin
      // R13: JTAG data in, pulled up
      alt_en[DPS_PAD_PC3] = 1'b1;
      pu[DPS_PAD_PC3] = 1'b1;
    end

    // R15: only the debug bit frees port_c_pin4
    if (!dbg_gpio) begin
      alt_en[DPS_PAD_PC4] = 1'b1;
      pu[DPS_PAD_PC4] = 1'b1;
      if (sw_mode) begin
        // R18: serial-wire data
        alt_out[DPS_PAD_PC4] = sw_data_drive_in;
        alt_oe[DPS_PAD_PC4] = sw_data_oe_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pad cells
  // ----------------------------------------------------------------
  for (genvar i = 0; i < DPS_NPAD; i++) begin : g_pad
    dps_pad_cell u_cell (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .alt_en_in(alt_en[i]),
      .alt_out_in(alt_out[i]),
      .alt_oe_in(alt_oe[i]),
      .gp_out_in(gp_out[i]),
      .gp_oe_in(gp_oe[i]),
      .pull_up_in(pu[i]),
      .pull_down_in(pd[i]),
      .pad_out(pad_out[i]),
      .pad_oe_out(pad_oe_out[i]),
      .pull_up_out(pad_pull_up_out[i]),
      .pull_down_out(pad_pull_down_out[i])
    );
  end

  // ----------------------------------------------------------------
  // Serial controller and timer inputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      serctl1_spi_master_in_out <= DPS_PAD_RST;
      serctl1_spi_slave_in_out <= DPS_PAD_RST;
      serctl1_uart_receive_out <= DPS_IDLE_HIGH;
      serctl1_twowire_clock_out <= DPS_IDLE_HIGH;
      timer2_channel2_out <= DPS_PAD_RST;
    end else if (ce_in) begin
      // R1: master data in
      serctl1_spi_master_in_out <= sc_spi && serctl1_spi_config_master_in &&
                                   pad_in[DPS_PAD_PB2];
      // R2: slave data in
      serctl1_spi_slave_in_out <= sc_spi && !serctl1_spi_config_master_in &&
                                  pad_in[DPS_PAD_PB2];
      // R4: UART receive, idle high otherwise
      serctl1_uart_receive_out <= sc_uart ? pad_in[DPS_PAD_PB2] : 1'b1;
      serctl1_twowire_clock_out <= scl_sel ? pad_in[DPS_PAD_PB2] : 1'b1;
      // R6: timer input needs remap
      timer2_channel2_out <= t2_remap && pad_in[DPS_PAD_PB2];
    end
  end

  // ----------------------------------------------------------------
  // Debug inputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      jtag_clock_pin_out <= DPS_PAD_RST;
      jtag_data_in_pin_out <= DPS_IDLE_HIGH;
      jtag_mode_select_pin_out <= DPS_IDLE_HIGH;
      sw_clock_out <= DPS_PAD_RST;
      sw_data_out <= DPS_IDLE_HIGH;
    end else if (ce_in) begin
      // R7: clock by mode
      jtag_clock_pin_out <= jtag_mode && pad_in[DPS_PAD_DCK];
      sw_clock_out <= sw_mode && pad_in[DPS_PAD_DCK];
      jtag_data_in_pin_out <= (jtag_mode && !pc3_gpio && !pc3_clk) ?
                              pad_in[DPS_PAD_PC3] : 1'b1;
      // R17: mode select in JTAG
      jtag_mode_select_pin_out <= (jtag_mode && !dbg_gpio) ?
                                  pad_in[DPS_PAD_PC4] : 1'b1;
      sw_data_out <= (sw_mode && !dbg_gpio) ? pad_in[DPS_PAD_PC4] : 1'b1;
    end
  end

  // GPIO input samples follow the pads in every mode
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      gpio_sample_out <= '0;
    end else if (ce_in) begin
      gpio_sample_out <= {pad_in[DPS_PAD_PC4:DPS_PAD_PC2],
                          pad_in[DPS_PAD_PB2]};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_spi_master;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && sc_spi && serctl1_spi_config_master_in |=>
      serctl1_spi_master_in_out == $past(pad_in[DPS_PAD_PB2]);
  endproperty
  a_spi_master: assert property (p_spi_master) // R1
    else $error("SPI master data in not routed");

  property p_uart_rx;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && sc_uart |=>
      serctl1_uart_receive_out == $past(pad_in[DPS_PAD_PB2]);
  endproperty
  a_uart_rx: assert property (p_uart_rx) // R4
    else $error("UART receive not routed");

  property p_scl_od;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && scl_sel |=> !pad_out[DPS_PAD_PB2] &&
      pad_oe_out[DPS_PAD_PB2] == $past(serctl1_twowire_drive_low_in);
  endproperty
  a_scl_od: assert property (p_scl_od) // R3
    else $error("Two-wire clock not open drain");

  property p_t2_drive;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && t2_drive |=> pad_oe_out[DPS_PAD_PB2] &&
      pad_out[DPS_PAD_PB2] == $past(timer2_channel2_drive_in);
  endproperty
  a_t2_drive: assert property (p_t2_drive) // R5
    else $error("Timer channel not driving pin");

  property p_jtag_clock;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && jtag_mode |=> pad_pull_down_out[DPS_PAD_DCK] &&
      !pad_oe_out[DPS_PAD_DCK];
  endproperty
  a_jtag_clock: assert property (p_jtag_clock) // R7
    else $error("JTAG clock pin not input with pull-down");

  property p_tdo;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && pc2_tdo && !pc2_sync |=> pad_oe_out[DPS_PAD_PC2] &&
      pad_out[DPS_PAD_PC2] == $past(jtag_data_out_in);
  endproperty
  a_tdo: assert property (p_tdo) // R9
    else $error("JTAG data out not driven");

  property p_pc4_gpio;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && dbg_gpio |=> pad_oe_out[DPS_PAD_PC4] == $past(gpio_oe_in[3])
      && !pad_pull_up_out[DPS_PAD_PC4];
  endproperty
  a_pc4_gpio: assert property (p_pc4_gpio) // R15
    else $error("Port C pin 4 not released to GPIO");

  property p_tms;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && jtag_mode && !dbg_gpio |=> pad_pull_up_out[DPS_PAD_PC4] &&
      jtag_mode_select_pin_out == $past(pad_in[DPS_PAD_PC4]);
  endproperty
  a_tms: assert property (p_tms) // R17
    else $error("JTAG mode select not routed");

endmodule

/* File: sim/dps_far_side.sv */
// Purpose: Far side of the shared pads, debugger and serial parts
// Assumes: A pad the device drives follows the device
// Notes:   Undriven pad without a pull toggles every cycle
`timescale 1ns/1ps
module dps_far_side (
  input wire logic clk_in,
  input wire logic [4:0] pad_drv_in,
  input wire logic [4:0] pad_oe_in,
  input wire logic [4:0] pull_up_in,
  input wire logic [4:0] pull_down_in,
  input wire logic [4:0] far_en_in,
  input wire logic [4:0] far_val_in,
  output logic [4:0] pad_lvl_out
);
  // ----
  // Pad resolution
  // ----
  // Floating pad must never look stable
  logic [4:0] float_r = 5'h0a;
  always @(posedge clk_in) begin
    float_r <= ~float_r;
  end
  // debugger drives data once device lets go
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pad_lvl_out[i] = pad_oe_in[i] ? pad_drv_in[i] :
        far_en_in[i] ? far_val_in[i] : pull_up_in[i] ? 1'h1 :
        pull_down_in[i] ? 1'h0 : float_r[i];
    end
  end
endmodule

/* File: sim/tb_dps_pin_select.sv */
// Purpose: Self-checking bench for the pin function select
// Assumes: Inputs move 1 ns after the rising edge
// Notes:   Three edges cover mode flop plus pad feedback
`timescale 1ns/1ps
module tb_dps_pin_select;
  import dps_pkg::*;
  // ----
  // Signals and instances
  // ----
  logic clk_in = 1'h0, rst_in = 1'h1, ce_in = 1'h1;
  logic external_reset_pin_n_in = 1'h1, sw_switch_req_in = 1'h0;
  logic [1:0] serctl1_mode_select_in = 2'h0;
  logic serctl1_spi_config_master_in = 1'h0;
  logic serctl1_twowire_drive_low_in = 1'h0;
  logic timer2_output_enable_reg_in = 1'h0;
  logic timer2_channel2_drive_in = 1'h0;
  logic [7:0] timer2_remap_reg_in = 8'h00, debug_pin_config_in = 8'h00;
  logic [15:0] port_b_low_config_in = 16'h0000;
  logic [15:0] port_c_low_config_in = 16'h0000;
  logic [15:0] port_c_high_config_in = 16'h0000;
  logic trace_enable_in = 1'h0, trace_async_sel_in = 1'h0;
  logic trace_sync4_sel_in = 1'h0, async_trace_data_in = 1'h0;
  logic sync_trace_data_in = 1'h0, sync_trace_clock_in = 1'h0;
  logic jtag_data_out_in = 1'h0, sw_clock_drive_in = 1'h0;
  logic sw_clock_oe_in = 1'h0, sw_data_drive_in = 1'h0, sw_data_oe_in = 1'h0;
  logic [3:0] gpio_drive_in = 4'h0, gpio_oe_in = 4'h0, gpio_sample_out;
  logic [4:0] far_en = 5'h00, far_val = 5'h00, pad_in, pad_out;
  logic [4:0] pad_oe_out, pad_pull_up_out, pad_pull_down_out;
  logic serctl1_spi_master_in_out, serctl1_spi_slave_in_out;
  logic serctl1_uart_receive_out, serctl1_twowire_clock_out;
  logic timer2_channel2_out, jtag_clock_pin_out, jtag_data_in_pin_out;
  logic jtag_mode_select_pin_out, sw_clock_out, sw_data_out;
  logic debug_sw_mode_out;
  int err_count = 0, check_count = 0;

  dps_pin_select dps_pin_select_i (.clk_in, .rst_in, .ce_in,
    .external_reset_pin_n_in, .sw_switch_req_in, .serctl1_mode_select_in,
    .serctl1_spi_config_master_in, .serctl1_twowire_drive_low_in,
    .timer2_output_enable_reg_in, .timer2_remap_reg_in,
    .timer2_channel2_drive_in, .port_b_low_config_in,
    .port_c_low_config_in, .port_c_high_config_in, .debug_pin_config_in,
    .trace_enable_in, .trace_async_sel_in, .trace_sync4_sel_in,
    .async_trace_data_in, .sync_trace_data_in, .sync_trace_clock_in,
    .jtag_data_out_in, .sw_clock_drive_in, .sw_clock_oe_in,
    .sw_data_drive_in, .sw_data_oe_in, .gpio_drive_in, .gpio_oe_in,
    .pad_in, .pad_out, .pad_oe_out, .pad_pull_up_out, .pad_pull_down_out,
    .gpio_sample_out, .serctl1_spi_master_in_out, .serctl1_spi_slave_in_out,
    .serctl1_uart_receive_out, .serctl1_twowire_clock_out,
    .timer2_channel2_out, .jtag_clock_pin_out, .jtag_data_in_pin_out,
    .jtag_mode_select_pin_out, .sw_clock_out, .sw_data_out,
    .debug_sw_mode_out);

  dps_far_side dps_far_side_i (.clk_in, .pad_drv_in(pad_out),
    .pad_oe_in(pad_oe_out), .pull_up_in(pad_pull_up_out),
    .pull_down_in(pad_pull_down_out), .far_en_in(far_en),
    .far_val_in(far_val), .pad_lvl_out(pad_in));

  // ----
  // Shared tasks
  // ----
  task automatic tick(int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic chk(string nm, logic e, logic g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %b got %b", nm, e, g);
    end
  endtask

  task automatic final_report();
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic pb2_mode(logic [1:0] md, logic ms, logic v);
    serctl1_mode_select_in = md;
    serctl1_spi_config_master_in = ms;
    far_en = 5'h01;
    far_val = {4'h0, v};
    tick(3);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_jtag_default();
    jtag_data_out_in = 1'h1;
    far_en = 5'h1a;
    far_val = 5'h02;
    tick(3);
    chk("sw_mode", 1'h0, debug_sw_mode_out);
    chk("dck_pd", 1'h1, pad_pull_down_out[1]);
    chk("dck_oe", 1'h0, pad_oe_out[1]);
    chk("jtag_clock_pin", 1'h1, jtag_clock_pin_out);
    chk("tdo_oe", 1'h1, pad_oe_out[2]);
    chk("tdo", 1'h1, pad_out[2]);
    chk("tdi_pu", 1'h1, pad_pull_up_out[3]);
    chk("tdi", 1'h0, jtag_data_in_pin_out);
    chk("tms_pu", 1'h1, pad_pull_up_out[4]);
    chk("tms", 1'h0, jtag_mode_select_pin_out);
    far_en = 5'h00;
    tick(3);
    chk("tdi_idle", 1'h1, jtag_data_in_pin_out);
    chk("jtag_clock_pin_idle", 1'h0, jtag_clock_pin_out);
  endtask

  task automatic t_pb2_serial();
    for (int v = 0; v < 2; v++) begin
      pb2_mode(DPS_SC_SPI, 1'h1, v[0]);
      chk("spi_m", v[0], serctl1_spi_master_in_out);
      chk("spi_s_off", 1'h0, serctl1_spi_slave_in_out);
      chk("uart_off", 1'h1, serctl1_uart_receive_out);
      chk("pb2_oe", 1'h0, pad_oe_out[0]);
      chk("gp_in", v[0], gpio_sample_out[0]);
      pb2_mode(DPS_SC_SPI, 1'h0, v[0]);
      chk("spi_s", v[0], serctl1_spi_slave_in_out);
      chk("spi_m_off", 1'h0, serctl1_spi_master_in_out);
      pb2_mode(DPS_SC_UART, 1'h0, v[0]);
      chk("uart", v[0], serctl1_uart_receive_out);
      chk("spi_s_off2", 1'h0, serctl1_spi_slave_in_out);
    end
  endtask

  task automatic t_twowire_timer();
    serctl1_mode_select_in = DPS_SC_TWI;
    port_b_low_config_in = 16'h0d00;
    serctl1_twowire_drive_low_in = 1'h1;
    timer2_output_enable_reg_in = 1'h1;
    far_val = 5'h00;
    tick(3);
    chk("scl_oe", 1'h1, pad_oe_out[0]);
    chk("scl_lo", 1'h0, pad_out[0]);
    chk("t2_in_off", 1'h0, timer2_channel2_out);
    serctl1_twowire_drive_low_in = 1'h0;
    far_en = 5'h01;
    tick(3);
    chk("scl_rel", 1'h0, pad_oe_out[0]);
    chk("scl_in", 1'h0, serctl1_twowire_clock_out);
    far_en = 5'h00;
    serctl1_twowire_drive_low_in = 1'h1;
    timer2_remap_reg_in = 8'h20;
    gpio_oe_in = 4'h1;
    gpio_drive_in = 4'h1;
    tick(3);
    chk("gp_oe", 1'h1, pad_oe_out[0]);
    chk("gp_out", 1'h1, pad_out[0]);
    chk("t2_in", 1'h1, timer2_channel2_out);
    port_b_low_config_in = 16'h0900;
    tick(3);
    chk("t2_oe", 1'h1, pad_oe_out[0]);
    chk("t2_out", 1'h0, pad_out[0]);
    timer2_output_enable_reg_in = 1'h0;
    tick(3);
    chk("t2_dis", 1'h1, pad_out[0]);
  endtask

  task automatic t_trace();
    trace_enable_in = 1'h1;
    trace_sync4_sel_in = 1'h1;
    port_c_low_config_in = 16'h9900;
    sync_trace_data_in = 1'h1;
    sync_trace_clock_in = 1'h1;
    jtag_data_out_in = 1'h0;
    tick(3);
    chk("trd", 1'h1, pad_out[2]);
    chk("trc", 1'h1, pad_out[3]);
    chk("trc_oe", 1'h1, pad_oe_out[3]);
    trace_sync4_sel_in = 1'h0;
    trace_async_sel_in = 1'h1;
    async_trace_data_in = 1'h1;
    port_c_low_config_in = 16'h0900;
    tick(3);
    chk("swo_jtag", 1'h0, pad_out[2]);
    chk("trc_off", 1'h0, pad_oe_out[3]);
  endtask

  task automatic t_release();
    trace_enable_in = 1'h0;
    debug_pin_config_in = 8'h20;
    gpio_oe_in = 4'he;
    gpio_drive_in = 4'ha;
    tick(3);
    chk("pc2_gp", 1'h1, pad_out[2]);
    chk("pc3_gp_oe", 1'h1, pad_oe_out[3]);
    chk("pc3_gp", 1'h0, pad_out[3]);
    chk("pc4_gp_oe", 1'h1, pad_oe_out[4]);
    chk("pc4_gp", 1'h1, pad_out[4]);
    port_c_high_config_in = 16'h0002;
    tick(3);
    chk("pc2_blk", 1'h0, pad_out[2]);
    debug_pin_config_in = 8'h00;
    tick(3);
    chk("pc4_rel", 1'h0, pad_oe_out[4]);
    chk("pc3_rel", 1'h0, pad_oe_out[3]);
  endtask

  task automatic t_swd();
    trace_enable_in = 1'h1;
    sw_clock_oe_in = 1'h1;
    sw_clock_drive_in = 1'h1;
    sw_data_oe_in = 1'h1;
    gpio_oe_in = 4'h4;
    gpio_drive_in = 4'h4;
    sw_switch_req_in = 1'h1;
    tick(1);
    sw_switch_req_in = 1'h0;
    tick(3);
    chk("sw_mode", 1'h1, debug_sw_mode_out);
    chk("swdio_oe", 1'h1, pad_oe_out[4]);
    chk("swdio", 1'h0, pad_out[4]);
    chk("swdio_pu", 1'h1, pad_pull_up_out[4]);
    chk("swclk", 1'h1, pad_out[1]);
    chk("swclk_pd", 1'h0, pad_pull_down_out[1]);
    chk("swclk_in", 1'h1, sw_clock_out);
    chk("swo", 1'h1, pad_out[2]);
    chk("swo_pu", 1'h1, pad_pull_up_out[2]);
    chk("pc3_sw", 1'h1, pad_out[3]);
    sw_data_oe_in = 1'h0;
    far_en = 5'h10;
    far_val = 5'h00;
    tick(3);
    chk("swdio_in", 1'h0, sw_data_out);
    external_reset_pin_n_in = 1'h0;
    sw_switch_req_in = 1'h1;
    tick(1);
    external_reset_pin_n_in = 1'h1;
    sw_switch_req_in = 1'h0;
    tick(3);
    chk("rst_pin", 1'h0, debug_sw_mode_out);
    chk("dck_pd2", 1'h1, pad_pull_down_out[1]);
  endtask

  // ----
  // Main sequence and watchdog
  // ----
  initial begin
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    repeat (16) @(posedge clk_in);
    #1 rst_in = 1'h0;
    t_jtag_default();
    t_pb2_serial();
    t_twowire_timer();
    t_trace();
    t_release();
    t_swd();
    final_report();
  end

  // Tests need about 81 cycles
  initial begin
    repeat (2000) @(posedge clk_in);
    err_count++;
    final_report();
  end
endmodule
